// file: pkg/sbi_pkg.sv
/*
  Shared constants for the SDRAM burst interrupt and suspend core:
  pin widths, command codes, burst length codes and latencies.
  Assumes commands are coded on {cs_n, ras_n, cas_n, we_n}.
*/
package sbi_pkg;

  // ----------------------------------------------------------------
  // Widths and address fields
  // ----------------------------------------------------------------
  localparam int DATA_W    = 16;
  localparam int BYTE_W    = 8;
  localparam int ADDR_W    = 12;
  localparam int ROW_W     = 11;
  localparam int COL_W     = 8;
  localparam int BANKS     = 2;
  localparam int BANK_BIT  = 11;
  localparam int AP_BIT    = 10;
  localparam int STORE_W   = 1 + ROW_W + COL_W + 2 + DATA_W;
  localparam int STORE_DEPTH = 2;

  // ----------------------------------------------------------------
  // Commands and burst codes
  // ----------------------------------------------------------------
  localparam logic [3:0] CMD_ACT   = 4'h3;
  localparam logic [3:0] CMD_READ  = 4'h5;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_PRE   = 4'h2;
  localparam logic [3:0] CMD_STOP  = 4'h6;

  localparam logic [2:0] BL_1    = 3'h0;
  localparam logic [2:0] BL_2    = 3'h1;
  localparam logic [2:0] BL_4    = 3'h2;
  localparam logic [2:0] BL_8    = 3'h3;
  localparam logic [2:0] BL_FULL = 3'h7;

  localparam logic [COL_W-1:0] WRAP_1    = 8'h00;
  localparam logic [COL_W-1:0] WRAP_2    = 8'h01;
  localparam logic [COL_W-1:0] WRAP_4    = 8'h03;
  localparam logic [COL_W-1:0] WRAP_8    = 8'h07;
  localparam logic [COL_W-1:0] WRAP_FULL = 8'hff;

  // ----------------------------------------------------------------
  // Latencies in clock cycles
  // ----------------------------------------------------------------
  localparam int READ_MASK_LATENCY   = 2;
  localparam int WRITE_RECOVERY_TIME = 2;
  localparam int CAS_LAT_TWO         = 2;
  localparam int CAS_LAT_THREE       = 3;

  typedef enum logic [1:0] {SBI_IDLE, SBI_READ, SBI_WRITE} sbi_state_type;

  // Column wrap mask, also the count of words after the first
  function automatic logic [COL_W-1:0] sbi_wrap(input logic [2:0] code);
    unique case (code)
      BL_2:    sbi_wrap = WRAP_2;
      BL_4:    sbi_wrap = WRAP_4;
      BL_8:    sbi_wrap = WRAP_8;
      BL_FULL: sbi_wrap = WRAP_FULL;
      default: sbi_wrap = WRAP_1;
    endcase
  endfunction

endpackage

// file: core/sbi_store_buffer.sv
/*
  Small valid/ready FIFO between the write burst engine and storage.
  Assumes both sides run on clk; the drain side may stall freely.
*/
`timescale 1ns/10ps
module sbi_store_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  // ----------------------------------------------------------------
  // Storage and pointers
  // ----------------------------------------------------------------
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PTR_W:0]   FULL_COUNT = (PTR_W+1)'(DEPTH);
  localparam logic [PTR_W-1:0] LAST_PTR   = PTR_W'(DEPTH - 1);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PTR_W-1:0] wr_ptr_reg;
  logic [PTR_W-1:0] rd_ptr_reg;
  logic [PTR_W:0]   count_reg;
  logic             push;
  logic             pop;

  // Honest flags straight from the occupancy count
  assign in_ready  = count_reg != FULL_COUNT;
  assign out_valid = count_reg != '0;
  assign out_data  = mem_reg[rd_ptr_reg];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Data words need no reset, only the pointers and count do
  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  // Pointer and occupancy update
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == LAST_PTR) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == LAST_PTR) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

endmodule

// file: core/sbi_sdram_burst_core.sv
/*
  Two-bank SDRAM burst engine: precharge and burst-stop termination,
  byte masking, burst-read/single-write and clock suspend.
  Assumes pins arrive from outside the clk domain and that storage
  answers a fetch with data in the same cycle.
*/
`timescale 1ns/10ps
module sbi_sdram_burst_core
  import sbi_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              arst_n,
  // Command pins
  input  wire logic              cs_n,
  input  wire logic              ras_n,
  input  wire logic              cas_n,
  input  wire logic              we_n,
  input  wire logic              cke,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic              upper_byte_mask,
  input  wire logic              lower_byte_mask,
  // Data pins
  input  wire logic [DATA_W-1:0] dq_in,
  output logic [DATA_W-1:0]      dq_out,
  output logic [1:0]             dq_oe,
  // Mode settings
  input  wire logic              cas_latency_three,
  input  wire logic [2:0]        burst_len_code,
  input  wire logic              single_write_mode,
  // Storage write stream
  output logic                   store_valid,
  input  wire logic              store_ready,
  output logic                   store_bank,
  output logic [ROW_W-1:0]       store_row,
  output logic [COL_W-1:0]       store_col,
  output logic [1:0]             store_byte_en,
  output logic [DATA_W-1:0]      store_data,
  // Storage read port
  output logic                   fetch_en,
  output logic                   fetch_bank,
  output logic [ROW_W-1:0]       fetch_row,
  output logic [COL_W-1:0]       fetch_col,
  input  wire logic [DATA_W-1:0] fetch_data,
  // Status
  output logic                   suspended,
  output logic                   write_stall,
  output logic [BANKS-1:0]       bank_open
);

  // ----------------------------------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------------------------------
  localparam int PIN_W = 4 + 1 + ADDR_W + 2 + DATA_W;

  logic             rst_s1_reg;
  logic             rst_n_reg;
  logic [PIN_W-1:0] pin_s1_reg;
  logic [PIN_W-1:0] pin_s2_reg;

  // Release is synchronous so no flop sees a ragged deassertion
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_reg <= 1'b0;
      rst_n_reg  <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n_reg  <= rst_s1_reg;
    end
  end

  // Two stages on every pin; only the second stage is decoded
  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
    end else begin
      pin_s1_reg <= {cs_n, ras_n, cas_n, we_n, cke, addr,
                     upper_byte_mask, lower_byte_mask, dq_in};
      pin_s2_reg <= pin_s1_reg;
    end
  end

  logic              p_cs_n;
  logic              p_ras_n;
  logic              p_cas_n;
  logic              p_we_n;
  logic              p_cke;
  logic [ADDR_W-1:0] p_addr;
  logic              p_umask;
  logic              p_lmask;
  logic [DATA_W-1:0] p_dq;

  assign {p_cs_n, p_ras_n, p_cas_n, p_we_n, p_cke, p_addr,
          p_umask, p_lmask, p_dq} = pin_s2_reg;

  // ----------------------------------------------------------------
  // Clock suspend and command decode
  // ----------------------------------------------------------------
  logic run_reg;

  // Enable seen at one edge governs the following edge
  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      run_reg <= 1'b0;
    end else begin
      run_reg <= p_cke;
    end
  end

  sbi_state_type     state_reg;
  logic              bank_reg;
  logic [COL_W-1:0]  col_reg;
  logic [COL_W-1:0]  left_reg;
  logic [COL_W-1:0]  wrap_reg;
  logic              full_reg;
  logic              auto_pre_reg;
  logic [ROW_W-1:0]  row_reg [BANKS];
  logic [BANKS-1:0]  bank_open_reg;

  logic [3:0]        cmd;
  logic              is_act;
  logic              is_read;
  logic              is_write;
  logic              is_pre;
  logic              is_stop;
  logic              cmd_bank;
  logic              cmd_ap;
  logic [COL_W-1:0]  cmd_col;
  logic [COL_W-1:0]  cmd_wrap;
  logic              new_col;
  logic              pre_hit;
  logic              plain;
  logic [1:0]        byte_en;
  logic              store_want;
  logic              fetch_want;
  logic              buf_in_ready;
  logic              stall;
  logic              adv;
  logic              cur_bank;
  logic [COL_W-1:0]  cur_col;
  logic              cmd_last;
  logic              word_last;

  // Nothing decodes while suspended
  assign cmd      = {p_cs_n, p_ras_n, p_cas_n, p_we_n};
  assign is_act   = run_reg && cmd == CMD_ACT;
  assign is_read  = run_reg && cmd == CMD_READ;
  assign is_write = run_reg && cmd == CMD_WRITE;
  assign is_pre   = run_reg && cmd == CMD_PRE;
  assign is_stop  = run_reg && cmd == CMD_STOP;
  assign cmd_bank = p_addr[BANK_BIT];
  assign cmd_ap   = p_addr[AP_BIT];
  assign cmd_col  = p_addr[COL_W-1:0];
  assign cmd_wrap = sbi_wrap(burst_len_code);
  assign new_col  = is_read || is_write;

  // Precharge ends a burst only on its own bank or on all banks
  assign pre_hit = is_pre && state_reg != SBI_IDLE &&
                   (cmd_ap || cmd_bank == bank_reg);
  // A suspended core neither stores nor fetches burst words
  assign plain   = run_reg && state_reg != SBI_IDLE && !new_col &&
                   !is_stop && !pre_hit;

  // Upper mask owns bit one of the byte enables
  assign byte_en = ~{p_umask, p_lmask};

  // A word is stored only on a live write cycle with a byte unmasked
  assign store_want = (is_write || (plain && state_reg == SBI_WRITE)) &&
                      (|byte_en);
  assign fetch_want = is_read || (plain && state_reg == SBI_READ);

  // A full buffer freezes the core like a suspend; pin data then drops
  assign stall       = store_want && !buf_in_ready;
  assign adv         = run_reg && !stall;
  assign write_stall = stall;
  assign suspended   = !run_reg;
  assign bank_open   = bank_open_reg;

  assign cur_bank = new_col ? cmd_bank : bank_reg;
  assign cur_col  = new_col ? cmd_col : col_reg;

  // Natural end of a burst, for auto-precharge
  assign cmd_last  = new_col && (cmd_wrap == WRAP_1 ||
                     (is_write && single_write_mode));
  assign word_last = plain && !full_reg && left_reg == 8'h01;

  // ----------------------------------------------------------------
  // Burst engine
  // ----------------------------------------------------------------
  // Sequential step inside the aligned burst block
  function automatic logic [COL_W-1:0] step_col(
    input logic [COL_W-1:0] col,
    input logic [COL_W-1:0] wrap
  );
    step_col = (col & ~wrap) | ((col + 1'b1) & wrap);
  endfunction

  // State, column and count; all frozen while not advancing
  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      state_reg    <= SBI_IDLE;
      bank_reg     <= 1'b0;
      col_reg      <= '0;
      left_reg     <= '0;
      wrap_reg     <= '0;
      full_reg     <= 1'b0;
      auto_pre_reg <= 1'b0;
    end else if (adv) begin
      if (new_col) begin
        bank_reg     <= cmd_bank;
        col_reg      <= step_col(cmd_col, cmd_wrap);
        wrap_reg     <= cmd_wrap;
        full_reg     <= burst_len_code == BL_FULL;
        auto_pre_reg <= cmd_ap && burst_len_code != BL_FULL;
        if (is_write && single_write_mode) begin
          left_reg  <= '0;
          state_reg <= SBI_IDLE;
        end else begin
          left_reg  <= cmd_wrap;
          state_reg <= (cmd_wrap == WRAP_1) ? SBI_IDLE :
                       (is_read ? SBI_READ : SBI_WRITE);
        end
      end else if (is_stop || pre_hit) begin
        state_reg <= SBI_IDLE;
      end else if (state_reg != SBI_IDLE) begin
        // Counter runs on even when both bytes are masked
        col_reg <= step_col(col_reg, wrap_reg);
        if (!full_reg) begin
          left_reg <= left_reg - 1'b1;
          if (left_reg == 8'h01) begin
            state_reg <= SBI_IDLE;
          end
        end
      end
    end
  end

  // Open rows and bank state
  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      bank_open_reg <= '0;
      for (int b = 0; b < BANKS; b++) begin
        row_reg[b] <= '0;
      end
    end else if (adv) begin
      if (is_act) begin
        bank_open_reg[cmd_bank] <= 1'b1;
        row_reg[cmd_bank]       <= p_addr[ROW_W-1:0];
      end else if (is_pre && cmd_ap) begin
        bank_open_reg <= '0;
      end else if (is_pre) begin
        bank_open_reg[cmd_bank] <= 1'b0;
      end else if ((cmd_last && cmd_ap) || (word_last && auto_pre_reg)) begin
        bank_open_reg[cur_bank] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Storage ports
  // ----------------------------------------------------------------
  logic [STORE_W-1:0] buf_out_data;

  assign fetch_en   = fetch_want && adv;
  assign fetch_bank = cur_bank;
  assign fetch_row  = row_reg[cur_bank];
  assign fetch_col  = cur_col;

  sbi_store_buffer #(
    .WIDTH (STORE_W),
    .DEPTH (STORE_DEPTH)
  ) u_store_buffer (
    .clk       (clk),
    .rst_n     (rst_n_reg),
    .in_valid  (store_want),
    .in_ready  (buf_in_ready),
    .in_data   ({cur_bank, row_reg[cur_bank], cur_col, byte_en, p_dq}),
    .out_valid (store_valid),
    .out_ready (store_ready),
    .out_data  (buf_out_data)
  );

  assign {store_bank, store_row, store_col, store_byte_en, store_data} =
    buf_out_data;

  // ----------------------------------------------------------------
  // Read output pipeline
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] pipe0_data_reg;
  logic [DATA_W-1:0] pipe1_data_reg;
  logic              pipe0_valid_reg;
  logic              pipe1_valid_reg;
  logic [1:0]        mask_d1_reg;
  logic [DATA_W-1:0] dq_out_reg;
  logic [1:0]        dq_oe_reg;
  logic              sel_valid;
  logic [DATA_W-1:0] sel_data;

  // Tap picks CAS latency; words already fetched drain after a stop
  assign sel_valid = cas_latency_three ? pipe1_valid_reg : pipe0_valid_reg;
  assign sel_data  = cas_latency_three ? pipe1_data_reg : pipe0_data_reg;
  assign dq_out    = dq_out_reg;
  assign dq_oe     = dq_oe_reg;

  // Mask passes one stage then gates the output flop: two cycles
  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      pipe0_data_reg  <= '0;
      pipe1_data_reg  <= '0;
      pipe0_valid_reg <= 1'b0;
      pipe1_valid_reg <= 1'b0;
      mask_d1_reg     <= '0;
      dq_out_reg      <= '0;
      dq_oe_reg       <= '0;
    end else if (adv) begin
      pipe0_data_reg  <= fetch_data;
      pipe0_valid_reg <= fetch_en;
      pipe1_data_reg  <= pipe0_data_reg;
      pipe1_valid_reg <= pipe0_valid_reg;
      mask_d1_reg     <= {p_umask, p_lmask};
      dq_out_reg      <= sel_data;
      dq_oe_reg       <= {2{sel_valid}} & ~mask_d1_reg;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n_reg);

  pre_stops_write_a: assert property (
    (is_pre && state_reg == SBI_WRITE && (cmd_ap || cmd_bank == bank_reg))
    |-> !store_want ##1 state_reg == SBI_IDLE || !adv)
    else $error("same-bank precharge did not stop write");

  other_bank_pre_a: assert property (
    (adv && is_pre && !cmd_ap && cmd_bank != bank_reg &&
     state_reg == SBI_WRITE && (full_reg || left_reg != 8'h01))
    |=> state_reg == SBI_WRITE)
    else $error("other-bank precharge ended write burst");

  full_page_step_a: assert property (
    (adv && plain && full_reg)
    |=> col_reg == COL_W'($past(col_reg) + 1'b1))
    else $error("full-page column did not wrap sequentially");

  read_latency_a: assert property (
    (adv && fetch_en && !cas_latency_three && !p_umask && !p_lmask)
    ##1 adv |=> dq_oe == 2'b11 && dq_out == $past(fetch_data, 2))
    else $error("read word not driven at latency two");

  read_drain_a: assert property (
    (adv && !fetch_en)[*3] |=> dq_oe == 2'b00)
    else $error("outputs not floated after read drained");

  read_mask_a: assert property (
    (adv && p_umask) ##1 adv |=> !dq_oe[1])
    else $error("upper byte driven two cycles after mask");

  write_mask_a: assert property (
    (store_want && buf_in_ready && p_lmask) |-> !byte_en[0] && !p_umask)
    else $error("masked lower byte offered for storage");

  stop_write_a: assert property (
    (adv && is_stop && state_reg == SBI_WRITE)
    |-> !store_want ##1 state_reg == SBI_IDLE)
    else $error("burst stop did not end write");

  masked_advance_a: assert property (
    (adv && plain && state_reg == SBI_WRITE && p_umask && p_lmask &&
     (full_reg || left_reg != 8'h01)) |=> col_reg != $past(col_reg))
    else $error("column stalled on masked write cycle");

  single_write_a: assert property (
    (adv && is_write && single_write_mode) |=> state_reg == SBI_IDLE)
    else $error("single-write mode continued burst");

  suspend_hold_a: assert property (
    !run_reg |=> $stable(col_reg) && $stable(state_reg) && $stable(dq_oe))
    else $error("state moved during clock suspend");

  suspend_ignore_a: assert property (
    !run_reg |-> !fetch_en && !store_want && !is_act)
    else $error("command accepted during clock suspend");

  resume_edge_a: assert property (
    $rose(run_reg) |-> $past(p_cke) && !$past(p_cke, 2))
    else $error("suspend exit not on following edge");

  all_bank_pre_a: assert property (
    (adv && is_pre && cmd_ap) |=> bank_open_reg == '0)
    else $error("all-bank precharge left a bank open");

endmodule

// file: dv/sbi_ctrl_model.sv
/*
  Controller-side pin model for the SDRAM burst core bench.
  Assumes the bench sets requests just after each clk edge.
*/
`timescale 1ns/10ps
module sbi_ctrl_model
  import sbi_pkg::*;
(
  // Requests from the bench
  input  wire logic [3:0]        cmd,
  input  wire logic              drive,
  input  wire logic [DATA_W-1:0] wdata,
  // Pins toward the core
  output logic                   cs_n,
  output logic                   ras_n,
  output logic                   cas_n,
  output logic                   we_n,
  output logic [DATA_W-1:0]      dq_in
);
  // Command code straight onto the strobes
  assign {cs_n, ras_n, cas_n, we_n} = cmd;
  // Released bus shows the inverse, so a stale word never passes
  assign dq_in = drive ? wdata : ~wdata;
endmodule

// file: dv/sbi_sdram_burst_core_test.sv
/*
  Self-checking bench for the SDRAM burst core.
  Assumes storage answers fetches at once and may stall stores.
*/
`timescale 1ns/10ps
module sbi_sdram_burst_core_test;
  import sbi_pkg::*;
  localparam logic [ROW_W-1:0] ROW = 11'h2a5;
  logic              clk = 1'b0;
  logic              arst_n = 1'b0;
  logic              cke = 1'b1;
  logic              drive = 1'b0;
  logic [3:0]        cmd = 4'h7;
  logic [ADDR_W-1:0] addr = '0;
  logic              upper_byte_mask = 1'b0;
  logic              lower_byte_mask = 1'b0;
  logic [DATA_W-1:0] wdata = '0;
  logic              cas_latency_three = 1'b0;
  logic [2:0]        burst_len_code = BL_1;
  logic              single_write_mode = 1'b0;
  logic              store_ready = 1'b1;
  logic              cs_n, ras_n, cas_n, we_n, store_valid, store_bank;
  logic              fetch_en, fetch_bank, suspended, write_stall;
  logic [DATA_W-1:0] dq_in, dq_out, store_data, fetch_data;
  logic [1:0]        dq_oe, store_byte_en, bank_open;
  logic [ROW_W-1:0]  store_row, fetch_row;
  logic [COL_W-1:0]  store_col, fetch_col;
  logic [26:0]       wq[$];
  logic [17:0]       rq[$];
  logic [1:0]        mk[0:511];
  int                bad_count = 0;
  int                check_count = 0;
  int                seed = 49870;

  // 250 MHz clock
  always #2 clk = ~clk;
  // Storage answers in the fetch cycle, with a traceable word
  assign fetch_data = {fetch_bank, fetch_row[6:0], fetch_col};

  sbi_ctrl_model u_sbi_ctrl_model (.cmd(cmd), .drive(drive),
    .wdata(wdata), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .dq_in(dq_in));

  sbi_sdram_burst_core u_sbi_sdram_burst_core (.clk(clk),
    .arst_n(arst_n), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .cke(cke), .addr(addr),
    .upper_byte_mask(upper_byte_mask), .lower_byte_mask(lower_byte_mask),
    .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
    .cas_latency_three(cas_latency_three), .burst_len_code(burst_len_code),
    .single_write_mode(single_write_mode), .store_valid(store_valid),
    .store_ready(store_ready), .store_bank(store_bank),
    .store_row(store_row), .store_col(store_col),
    .store_byte_en(store_byte_en), .store_data(store_data),
    .fetch_en(fetch_en), .fetch_bank(fetch_bank), .fetch_row(fetch_row),
    .fetch_col(fetch_col), .fetch_data(fetch_data),
    .suspended(suspended), .write_stall(write_stall),
    .bank_open(bank_open));

  function automatic logic [15:0] bx(input logic [1:0] e);
    return {{8{e[1]}}, {8{e[0]}}};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stop_test;
    if (bad_count == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // One pin cycle; data is random and returned for the notes
  task automatic step(input logic [3:0] c, input logic [11:0] a,
                      input logic [1:0] m, input logic d,
                      output logic [15:0] v);
    @(posedge clk);
    v = 16'($random(seed));
    cmd <= c;
    addr <= a;
    {upper_byte_mask, lower_byte_mask} <= m;
    drive <= d;
    wdata <= v;
  endtask

  // Activate, then idle out the row-to-column gap
  task automatic open(input logic b, input logic [2:0] code);
    logic [15:0] v;
    burst_len_code <= code;
    step(CMD_ACT, {b, ROW}, 2'h0, 1'b0, v);
    repeat (2) step(4'h7, 12'h0, 2'h0, 1'b0, v);
  endtask

  // Recovery gap, all-bank precharge, then both banks closed
  task automatic close;
    logic [15:0] v;
    repeat (2) step(4'h7, 12'h0, 2'h0, 1'b0, v);
    step(CMD_PRE, 12'h400, 2'h0, 1'b0, v);
    repeat (4) step(4'h7, 12'h0, 2'h0, 1'b0, v);
    chk(bank_open, 2'h0);
  endtask

  // Read k words (stop after k on full page) with random masks
  task automatic rd(input logic b, input logic [7:0] a,
                    input logic [2:0] code, input int k);
    logic [7:0]  w;
    logic [1:0]  m;
    logic [15:0] v;
    w = code == BL_FULL ? 8'hff : 8'((1 << code) - 1);
    for (int i = 0; i < 512; i++) mk[i] = 2'($random(seed));
    open(b, code);
    for (int i = 0; i < k + 6; i++) begin
      store_ready <= 1'($random(seed));
      step(i == 0 ? CMD_READ : (i == k && code == BL_FULL) ? CMD_STOP
           : 4'h7, {b, 3'h0, a}, mk[i], 1'b0, v);
      m = ~mk[i + cas_latency_three];
      if (i < k && m != 2'h0)
        rq.push_back({m, bx(m) & {b, ROW[6:0],
                      (a & ~w) | 8'(a + i) & w}});
    end
    store_ready <= 1'b1;
    close();
  endtask

  // Write burst; command ec at step k; optional clock suspend
  task automatic wr(input logic b, input logic [7:0] a,
                    input logic [2:0] code, input int k,
                    input logic [3:0] ec, input logic [11:0] ea,
                    input logic sus);
    logic [7:0]  w;
    logic [1:0]  m;
    logic [15:0] v;
    int          n;
    logic        live;
    w = code == BL_FULL ? 8'hff : 8'((1 << code) - 1);
    n = 0;
    live = 1'b1;
    open(b, code);
    for (int i = 0; i < k + 10; i++) begin
      m = 2'($random(seed));
      if (i == k && ec == CMD_PRE) m = 2'h3;
      // Set one edge ahead of step i, so steps 3 and 4 are suspended
      cke <= !(sus && (i == 3 || i == 4));
      step(i == 0 ? CMD_WRITE : i == k ? ec : (sus && i == 4) ? CMD_STOP
           : 4'h7, i == 0 ? {b, 3'h0, a} : ea, m, 1'b1, v);
      if (i == 6) chk(suspended, sus);
      if (i == k && ec != 4'h7 && (ec == CMD_STOP || ea[10] || ea[11] == b))
        live = 1'b0;
      if (!(sus && (i == 3 || i == 4))) begin
        if (live && (code == BL_FULL || n <= w) && m != 2'h3
            && (!single_write_mode || n == 0))
          wq.push_back({b, (a & ~w) | 8'(a + n) & w, ~m, v & bx(~m)});
        n++;
      end
    end
    close();
  endtask

  // ----------------------------------------------------------------
  // Result checking
  // ----------------------------------------------------------------
  // Oldest note is taken off as each result appears
  always @(posedge clk) begin
    if (store_valid && store_ready) begin
      chk({store_bank, store_col, store_byte_en, store_data
           & bx(store_byte_en)}, wq.size() ? wq.pop_front() : '1);
      chk(store_row, ROW);
    end
    if (dq_oe != 2'h0)
      chk({dq_oe, dq_out & bx(dq_oe)}, rq.size() ? rq.pop_front() : '1);
  end

  // Cut a hang short well past the expected run length
  initial begin
    #60000;
    bad_count++;
    stop_test();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    logic [15:0] v;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    repeat (7) @(posedge clk);
    for (int c = 0; c < 2; c++) begin
      cas_latency_three <= c[0];
      rd(c[0], 8'hfe, BL_FULL, 258);
      rd(1'b1, 8'h13, BL_FULL, 5);
      rd(1'b0, 8'h0e, BL_4, 4);
    end
    wr(1'b0, 8'hfd, BL_FULL, 258, CMD_STOP, 12'h0, 1'b0);
    wr(1'b1, 8'h21, BL_8, 3, CMD_PRE, 12'h800, 1'b0);
    wr(1'b0, 8'h21, BL_8, 3, CMD_PRE, 12'h800, 1'b0);
    wr(1'b0, 8'h22, BL_8, 4, CMD_PRE, 12'hc00, 1'b0);
    wr(1'b1, 8'h30, BL_FULL, 12, CMD_STOP, 12'h0, 1'b1);
    single_write_mode <= 1'b1;
    wr(1'b0, 8'h44, BL_4, 6, 4'h7, 12'h0, 1'b0);
    rd(1'b0, 8'h44, BL_4, 4);
    single_write_mode <= 1'b0;
    store_ready <= 1'b0;
    wr(1'b1, 8'h50, BL_2, 4, 4'h7, 12'h0, 1'b0);
    chk(write_stall, 1'b0);
    store_ready <= 1'b1;
    repeat (20) step(4'h7, 12'h0, 2'h0, 1'b0, v);
    chk(wq.size() + rq.size(), 0);
    stop_test();
  end
endmodule
